// [bench/lsr_spi_master.sv]
// SPI master model issuing command frames
`timescale 1ns/1ns
module lsr_spi_master (
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  logic [7:0] tx [32];
  logic [7:0] rx [32];
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end
  // Mode 0, 64 ns bit time; sclk still between frames
  task automatic frame(input int n);
    // Edges land exactly on rising pclk edges, 4 ns past each 8 ns boundary
    #(36 - $time % 8);
    spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--) begin
        spi_mosi = tx[i][b];
        #32 spi_sclk = 1'b1;
        rx[i][b] = spi_miso;
        #32 spi_sclk = 1'b0;
      end
    #32 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;  // Released line must not keep stale data
  endtask
  // Callers always add ambient to any active selection
  task automatic sm(input logic [3:0] opt, input logic [6:0] sel, input logic bad);
    tx[0] = {4'hD, opt};
    tx[1] = {sel, ^sel ^ bad};
    frame(2);
  endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the light sensor measure and read-out block
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {logic [1:0] en; logic [3:0] opt; logic [6:0] sel; logic [7:0] dur;} lsr_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, spi_sclk, spi_cs_n;
  logic spi_mosi, spi_miso, spi_miso_oe, data_ready_out, aa_filter_invert;
  logic sc_filter_offset_invert, conv_buffer_offset_invert, led_a_fire, led_b_fire;
  logic test_pulse_a, test_pulse_b, miso_line, miso_last;
  logic [4:0]   test_pulse_ua;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [143:0] afe_results;
  logic [7:0]   eq [$];
  int           bad_count, check_count, c;
  lsr_row_t     rows [4] = '{'{2'h3, 4'hA, 7'h20, 8'h3C}, '{2'h1, 4'h5, 7'h3F, 8'h64},
                            '{2'h3, 4'hE, 7'h7F, 8'hC8}, '{2'h3, 4'h0, 7'h40, 8'h28}};
  lsr_measure_readout #(.P_TEMP_CYC(20'h28), .P_AMB_CYC(20'h3C), .P_ACT_CYC(20'h50),
    .P_DCACT_CYC(20'h64), .P_ALL_CYC(20'hC8), .P_STARTUP_CYC(20'h1E)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .data_ready_out(data_ready_out), .afe_results(afe_results),
    .aa_filter_invert(aa_filter_invert), .sc_filter_offset_invert(sc_filter_offset_invert),
    .conv_buffer_offset_invert(conv_buffer_offset_invert), .led_a_fire(led_a_fire),
    .led_b_fire(led_b_fire), .test_pulse_a(test_pulse_a), .test_pulse_b(test_pulse_b),
    .test_pulse_ua(test_pulse_ua));
  lsr_spi_master u_spi (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(miso_line));
  // Released MISO shows the inverse of its last bit, so a late enable is seen
  always @(spi_miso or spi_miso_oe) begin
    if (spi_miso_oe) miso_last = spi_miso;
  end
  assign miso_line = spi_miso_oe ? spi_miso : ~miso_last;
  task automatic check(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic hang();
    bad_count++;
    finish_test();
  endtask
  task automatic wait_dr(input logic lvl, input int lim);
    c = 0;
    while (data_ready_out !== lvl && c < lim) begin
      @(posedge pclk);
      c++;
    end
    if (c == lim) hang();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (pready !== 1'b1 && c < 20);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (c == 20) hang();
  endtask
  function automatic logic [7:0] crc8(input int n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--)
        r = {r[6:0], 1'b0} ^ ((r[7] ^ u_spi.rx[i][b]) ? 8'h07 : 8'h00);
    return r;
  endfunction
  task automatic readout(input logic [6:0] s, input logic [1:0] en, input logic z);
    logic        on;
    logic [15:0] w;
    eq.delete();
    for (int p = 0; p < 10; p++) begin
      on = p == 0 ? s[6] : p == 1 ? s[5] & en[0] : p == 2 ? s[5] & en[1] : p == 3 ? s[5]
         : p == 6 ? s[1] : p == 7 ? s[0] : s[4];
      w = (p == 3 || z) ? 16'h0000 : afe_results[16 * (p < 3 ? p : p - 1) +: 16];
      if (on) eq = {eq, w[15:8], w[7:0]};
    end
    foreach (u_spi.tx[i]) u_spi.tx[i] = i == 0 ? 8'hC3 : 8'h00;
    u_spi.frame(eq.size() + 3);
    check(u_spi.rx[1], 8'hC3, "echo");
    foreach (eq[k]) check(u_spi.rx[k + 2], eq[k], "data byte");
    check(crc8(eq.size() + 3), 8'h00, "crc");
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #400000 hang();
  end
  initial begin
    lsr_row_t r;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    for (int i = 0; i < 9; i++) afe_results[16 * i +: 16] = 16'hA050 + 16'h0101 * i;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check(data_ready_out, 1'b1, "ready at reset");
    check(spi_miso_oe, 1'b0, "miso released at reset");
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h03, "ctrl reset");
    apb(1'b0, 12'h008, 32'h0);
    check(err, 1'b1, "unmapped");
    for (int a = 0; a < 4; a++) begin
      apb(1'b1, 12'h000, 32'h03 | (a << 2));
      repeat (2) @(posedge pclk);
      check(test_pulse_ua, 5'h05 + 5'(8 * a), "pulse amp");
    end
    foreach (rows[i]) begin
      r = rows[i];
      afe_results <= afe_results + {9{16'h1111}};
      apb(1'b1, 12'h000, {30'h0, r.en});
      u_spi.sm(r.opt, r.sel, 1'b0);
      wait_dr(1'b0, 50);
      repeat (2) @(posedge pclk);
      check({aa_filter_invert, sc_filter_offset_invert, conv_buffer_offset_invert, led_a_fire,
        led_b_fire, test_pulse_a, test_pulse_b}, {r.opt[3:1], {2{~r.opt[0]}} & r.sel[3:2],
        {2{r.opt[0]}} & r.sel[1:0]}, "front end");
      wait_dr(1'b1, 300);
      check(c + 2, r.dur, "ready low time");
      readout(r.sel, r.en, 1'b0);
    end
    readout(7'h40, 2'h3, 1'b1);
    u_spi.tx[0] = 8'hB0;
    u_spi.tx[1] = 8'h41;
    u_spi.frame(2);
    wait_dr(1'b0, 50);
    wait_dr(1'b1, 300);
    apb(1'b0, 12'h004, 32'h0);
    check(rd[14:8], 7'h20, "diag selection");
    check(rd[4], 1'b1, "diag command");
    u_spi.sm(4'h0, 7'h20, 1'b1);
    repeat (20) @(posedge pclk);
    check(data_ready_out, 1'b1, "bad parity start");
    apb(1'b0, 12'h004, 32'h0);
    check(rd[1], 1'b1, "invalid flag");
    apb(1'b1, 12'h004, 32'h2);
    u_spi.sm(4'h0, 7'h7F, 1'b0);
    wait_dr(1'b0, 50);
    u_spi.sm(4'h0, 7'h20, 1'b0);
    wait_dr(1'b1, 300);
    apb(1'b0, 12'h004, 32'h0);
    check(rd[14:8], 7'h7F, "busy selection");
    check(rd[1], 1'b0, "invalid cleared");
    check(data_ready_out, 1'b1, "busy start dropped");
    u_spi.sm(4'h0, 7'h7F, 1'b0);
    wait_dr(1'b0, 50);
    u_spi.tx[0] = 8'hF0;
    u_spi.frame(1);
    wait_dr(1'b1, 300);
    check(c <= 40, 1'b1, "reset in measurement");
    apb(1'b1, 12'h000, 32'h13);
    u_spi.sm(4'h0, 7'h20, 1'b0);
    repeat (20) @(posedge pclk);
    check(data_ready_out, 1'b1, "standby start");
    check(spi_miso_oe, 1'b0, "miso released");
    u_spi.tx[0] = 8'hF0;
    u_spi.frame(1);
    wait_dr(1'b0, 50);
    wait_dr(1'b1, 100);
    apb(1'b0, 12'h000, 32'h0);
    check(rd[4], 1'b0, "standby left");
    finish_test();
  end
endmodule

// [hw/lsr_measure_readout.sv]
// Light sensor measure and read-out: command decode, timing, frame serialiser
`timescale 1ns/1ns
`include "lsr_params.svh"

module lsr_measure_readout #(
  parameter logic [19:0] P_TEMP_CYC    = 20'(`T_TEMP_CYC),
  parameter logic [19:0] P_AMB_CYC     = 20'(`T_AMB_CYC),
  parameter logic [19:0] P_ACT_CYC     = 20'(`T_ACT_CYC),
  parameter logic [19:0] P_DCACT_CYC   = 20'(`T_DCACT_CYC),
  parameter logic [19:0] P_ALL_CYC     = 20'(`T_ALL_CYC),
  parameter logic [19:0] P_STARTUP_CYC = 20'(`T_STARTUP_CYC)
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [11:0]                        paddr,
  input  wire logic [31:0]                        pwdata,
  output wire logic [31:0]                        prdata,
  output wire logic                               pready,
  output wire logic                               pslverr,
  input  wire logic                               spi_sclk,
  input  wire logic                               spi_cs_n,
  input  wire logic                               spi_mosi,
  output wire logic                               spi_miso,
  output wire logic                               spi_miso_oe,
  output wire logic                               data_ready_out,
  input  wire logic [`AFE_SLOTS*`WORD_W-1:0]      afe_results,
  output wire logic                               aa_filter_invert,
  output wire logic                               sc_filter_offset_invert,
  output wire logic                               conv_buffer_offset_invert,
  output wire logic                               led_a_fire,
  output wire logic                               led_b_fire,
  output wire logic                               test_pulse_a,
  output wire logic                               test_pulse_b,
  output wire logic [4:0]                         test_pulse_ua
);

  logic [2:0]          sclk_sync_reg;
  logic [2:0]          cs_sync_reg;
  logic [2:0]          mosi_sync_reg;
  logic [2:0]          bit_cnt_reg;
  logic [4:0]          byte_cnt_reg;
  logic [7:0]          rx_sr_reg;
  logic [7:0]          ctl1_reg;
  logic [7:0]          second_control_byte;
  logic [7:0]          tx_sr_reg;
  logic [7:0]          crc_reg;
  logic [4:0]          rd_ptr_reg;
  logic                miso_reg;
  logic                miso_oe_reg;
  logic                ro_live_reg;
  lsr_pkg::lsr_state_t st_reg;
  logic [19:0]         cnt_reg;
  logic                dr_reg;
  logic [6:0]          meas_select_bits;
  logic [3:0]          opt_reg;
  logic                diag_reg;
  logic                valid_reg;
  logic [`WORD_W-1:0]  res_mem [0:`AFE_SLOTS-1];
  logic                ambient_c_enable;
  logic                ambient_d_enable;
  logic                pulse_amp_hi;
  logic                pulse_amp_lo;
  logic                standby_reg;
  logic                invalid_reg;
  logic [31:0]         prdata_reg;
  logic                pready_reg;
  logic                pslverr_reg;
  logic                aa_reg;
  logic                sc_reg;
  logic                cb_reg;
  logic                led_a_reg;
  logic                led_b_reg;
  logic                tp_a_reg;
  logic                tp_b_reg;
  logic [4:0]          pulse_ua_reg;
  logic [4:0]          nxt_idx;
  logic [7:0]          nxt_byte;
  logic [7:0]          data_byte;
  logic [`WORD_W-1:0]  word_sel;
  logic [7:0]          status_byte;

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int b = 0; b < 8; b++) begin
      r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Frame slot 3..22 presence; CRC slot always present
  function automatic logic byte_en(input logic [4:0] idx, input logic [6:0] s,
                                   input logic ac, input logic ad);
    case (idx)
      5'h03, 5'h04: byte_en = s[`SEL_TEMP];
      5'h05, 5'h06: byte_en = s[`SEL_AMB] & ac;
      5'h07, 5'h08: byte_en = s[`SEL_AMB] & ad;
      5'h09, 5'h0A: byte_en = s[`SEL_AMB];
      5'h0B, 5'h0C, 5'h0D, 5'h0E: byte_en = s[`SEL_DC];
      5'h0F, 5'h10: byte_en = s[`SEL_ACTA];
      5'h11, 5'h12: byte_en = s[`SEL_ACTB];
      5'h13, 5'h14, 5'h15, 5'h16: byte_en = s[`SEL_DC];
      `CRC_IDX: byte_en = 1'b1;
      default: byte_en = 1'b0;
    endcase
  endfunction

  // Duration table; active without ambient is never requested
  function automatic logic [19:0] meas_cycles(input logic [6:0] s);
    logic act;
    act = s[`SEL_ACTA] | s[`SEL_ACTB];
    if (act && s[`SEL_TEMP]) begin
      meas_cycles = P_ALL_CYC;
    end else if (act) begin
      meas_cycles = s[`SEL_DC] ? P_DCACT_CYC : P_ACT_CYC;
    end else if (s[`SEL_TEMP] && s[`SEL_AMB]) begin
      meas_cycles = 20'(P_TEMP_CYC + P_AMB_CYC);
    end else if (s[`SEL_TEMP]) begin
      meas_cycles = P_TEMP_CYC;
    end else if (s[`SEL_AMB] || s[`SEL_DC]) begin
      meas_cycles = P_AMB_CYC;
    end else begin
      meas_cycles = 20'h00001;
    end
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      mosi_sync_reg <= 3'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], spi_cs_n};
      mosi_sync_reg <= {mosi_sync_reg[1:0], spi_mosi};
    end
  end

  wire logic sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire logic sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire logic cs_fall   = ~cs_sync_reg[1] & cs_sync_reg[2];
  wire logic cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire logic cs_act    = ~cs_sync_reg[1];
  wire logic [7:0] rx_byte = {rx_sr_reg[6:0], mosi_sync_reg[1]};
  wire logic byte_done = cs_act & sclk_rise & (bit_cnt_reg == 3'h7);

  // Start and chip-reset commands execute on CS release; read-out is granted on the first byte
  wire logic is_sm   = ctl1_reg[7:4] == `CMD_SM_HI;
  wire logic is_sd   = ctl1_reg == `CMD_SD;
  wire logic cr_go   = cs_rise & (byte_cnt_reg != 5'h00) & (ctl1_reg == `CMD_CR);
  wire logic par_ok  = (^second_control_byte[7:1]) == second_control_byte[0];
  wire logic start_req = cs_rise & (byte_cnt_reg >= 5'h02) & (is_sm | is_sd)
                       & dr_reg & ~standby_reg;
  wire logic start_go = start_req & par_ok;
  wire logic par_err  = start_req & ~par_ok;
  wire logic ro_end   = cs_rise & ro_live_reg;
  wire logic wr_en    = psel & penable & pready_reg & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_reg         <= 3'h0;
      byte_cnt_reg        <= 5'h00;
      rx_sr_reg           <= 8'h00;
      ctl1_reg            <= 8'h00;
      second_control_byte <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 5'h00;
    end else if (cs_act && sclk_rise) begin
      rx_sr_reg   <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        if (byte_cnt_reg != 5'h1F) begin
          byte_cnt_reg <= byte_cnt_reg + 5'h01;
        end
        if (byte_cnt_reg == 5'h00) begin
          ctl1_reg <= rx_byte;
        end
        if (byte_cnt_reg == 5'h01) begin
          second_control_byte <= rx_byte;
        end
      end
    end
  end

  // Read-out granted only with data ready and no measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ro_live_reg <= 1'b0;
    end else if (cs_rise || cs_fall) begin
      ro_live_reg <= 1'b0;
    end else if (byte_done && byte_cnt_reg == 5'h00) begin
      ro_live_reg <= (rx_byte == `CMD_RO) & dr_reg & (st_reg == lsr_pkg::LSR_IDLE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg  <= lsr_pkg::LSR_IDLE;
      cnt_reg <= 20'h00000;
      dr_reg  <= 1'b1;
    end else if (cr_go) begin
      st_reg  <= lsr_pkg::LSR_STARTUP;
      cnt_reg <= P_STARTUP_CYC - 20'h00001;
      dr_reg  <= 1'b0;
    end else begin
      case (st_reg)
        lsr_pkg::LSR_IDLE: begin
          if (start_go) begin
            st_reg  <= lsr_pkg::LSR_MEAS;
            cnt_reg <= meas_cycles(second_control_byte[7:1]) - 20'h00001;
            dr_reg  <= 1'b0;
          end
        end
        lsr_pkg::LSR_MEAS, lsr_pkg::LSR_STARTUP: begin
          if (cnt_reg == 20'h00000) begin
            st_reg <= lsr_pkg::LSR_IDLE;
            dr_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 20'h00001;
          end
        end
        default: st_reg <= lsr_pkg::LSR_IDLE;
      endcase
    end
  end

  wire logic meas_end = (st_reg == lsr_pkg::LSR_MEAS) & (cnt_reg == 20'h00000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_select_bits <= 7'h00;
      opt_reg          <= 4'h0;
      diag_reg         <= 1'b0;
    end else if (cr_go) begin
      meas_select_bits <= 7'h00;
      opt_reg          <= 4'h0;
      diag_reg         <= 1'b0;
    end else if (start_go) begin
      meas_select_bits <= second_control_byte[7:1];
      opt_reg          <= is_sm ? ctl1_reg[3:0] : 4'h0;
      diag_reg         <= is_sd;
    end
  end

  // Results are captured only once, when the cycle ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_reg <= 1'b0;
      for (int i = 0; i < `AFE_SLOTS; i++) begin
        res_mem[i] <= '0;
      end
    end else if (cr_go || ro_end) begin
      valid_reg <= 1'b0;
      for (int i = 0; i < `AFE_SLOTS; i++) begin
        res_mem[i] <= '0;
      end
    end else if (meas_end) begin
      valid_reg <= 1'b1;
      for (int i = 0; i < `AFE_SLOTS; i++) begin
        res_mem[i] <= afe_results[i*`WORD_W +: `WORD_W];
      end
    end
  end

  always_comb begin
    nxt_idx = `CRC_IDX;
    for (int k = 22; k >= 3; k--) begin
      if (5'(k) >= rd_ptr_reg &&
          byte_en(5'(k), meas_select_bits, ambient_c_enable, ambient_d_enable)) begin
        nxt_idx = 5'(k);
      end
    end
  end

  always_comb begin
    if (nxt_idx < 5'h09) begin
      word_sel = res_mem[4'((nxt_idx - 5'h03) >> 1)];
    end else if (nxt_idx > 5'h0A && nxt_idx < `CRC_IDX) begin
      word_sel = res_mem[4'(((nxt_idx - 5'h0B) >> 1) + 5'h03)];
    end else begin
      word_sel = '0;
    end
    data_byte = nxt_idx[0] ? word_sel[15:8] : word_sel[7:0];
    if (byte_cnt_reg == 5'h01) begin
      nxt_byte = ctl1_reg;
    end else if (ro_live_reg && rd_ptr_reg <= `CRC_IDX) begin
      nxt_byte = (nxt_idx == `CRC_IDX) ? crc_reg : data_byte;
    end else begin
      nxt_byte = 8'h00;
    end
  end

  assign status_byte = {invalid_reg, 5'h00, standby_reg, dr_reg};

  // MISO changes on falling SCLK so master samples on rising
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sr_reg   <= 8'h00;
      miso_reg    <= 1'b0;
      miso_oe_reg <= 1'b0;
      rd_ptr_reg  <= `FIRST_IDX;
      crc_reg     <= `CRC_INIT;
    end else if (cs_fall) begin
      tx_sr_reg   <= status_byte;
      miso_reg    <= status_byte[7];
      miso_oe_reg <= 1'b1;
      rd_ptr_reg  <= `FIRST_IDX;
      crc_reg     <= crc8(`CRC_INIT, status_byte);
    end else if (cs_rise) begin
      miso_reg    <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else if (cs_act && sclk_fall) begin
      if (bit_cnt_reg == 3'h0) begin
        tx_sr_reg <= nxt_byte;
        miso_reg  <= nxt_byte[7];
        crc_reg   <= crc8(crc_reg, nxt_byte);
        if (ro_live_reg && byte_cnt_reg >= 5'h02 && rd_ptr_reg <= `CRC_IDX) begin
          rd_ptr_reg <= nxt_idx + 5'h01;
        end
      end else begin
        tx_sr_reg <= tx_sr_reg << 1;
        miso_reg  <= tx_sr_reg[6];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {standby_reg, pulse_amp_hi, pulse_amp_lo, ambient_d_enable, ambient_c_enable} <= `CTRL_RST;
    end else if (cr_go) begin
      standby_reg <= 1'b0;
    end else if (wr_en && paddr == `REG_CTRL) begin
      {standby_reg, pulse_amp_hi, pulse_amp_lo, ambient_d_enable, ambient_c_enable} <= pwdata[4:0];
    end
  end

  // Hardware set beats software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      invalid_reg <= 1'b0;
    end else if (par_err) begin
      invalid_reg <= 1'b1;
    end else if (cr_go || (wr_en && paddr == `REG_STAT && pwdata[`STAT_INV])) begin
      invalid_reg <= 1'b0;
    end
  end

  // One wait state: data registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg
                   & (paddr != `REG_CTRL) & (paddr != `REG_STAT);
      if (psel && penable && !pready_reg) begin
        case (paddr)
          `REG_CTRL: prdata_reg <= {27'h0000000, standby_reg, pulse_amp_hi, pulse_amp_lo,
                                    ambient_d_enable, ambient_c_enable};
          `REG_STAT: prdata_reg <= {17'h00000, meas_select_bits, 3'h0, diag_reg, valid_reg,
                                    st_reg == lsr_pkg::LSR_MEAS, invalid_reg, dr_reg};
          default:   prdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  wire logic measuring = (st_reg == lsr_pkg::LSR_MEAS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aa_reg       <= 1'b0;
      sc_reg       <= 1'b0;
      cb_reg       <= 1'b0;
      led_a_reg    <= 1'b0;
      led_b_reg    <= 1'b0;
      tp_a_reg     <= 1'b0;
      tp_b_reg     <= 1'b0;
      pulse_ua_reg <= `PULSE_BASE_UA;
    end else begin
      aa_reg       <= measuring & opt_reg[3];
      sc_reg       <= measuring & opt_reg[2];
      cb_reg       <= measuring & opt_reg[1];
      led_a_reg    <= measuring & ~opt_reg[0] & meas_select_bits[`SEL_LEDA];
      led_b_reg    <= measuring & ~opt_reg[0] & meas_select_bits[`SEL_LEDB];
      tp_a_reg     <= measuring & opt_reg[0] & meas_select_bits[`SEL_ACTA];
      tp_b_reg     <= measuring & opt_reg[0] & meas_select_bits[`SEL_ACTB];
      pulse_ua_reg <= `PULSE_BASE_UA + {pulse_amp_hi, pulse_amp_lo, 3'h0};
    end
  end

  assign prdata                    = prdata_reg;
  assign pready                    = pready_reg;
  assign pslverr                   = pslverr_reg;
  assign spi_miso                  = miso_reg;
  assign spi_miso_oe               = miso_oe_reg;
  assign data_ready_out            = dr_reg;
  assign aa_filter_invert          = aa_reg;
  assign sc_filter_offset_invert   = sc_reg;
  assign conv_buffer_offset_invert = cb_reg;
  assign led_a_fire                = led_a_reg;
  assign led_b_fire                = led_b_reg;
  assign test_pulse_a              = tp_a_reg;
  assign test_pulse_b              = tp_b_reg;
  assign test_pulse_ua             = pulse_ua_reg;

  default clocking ast_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [19:0] ast_low_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ast_low_cnt <= 20'h00000;
    end else if (dr_reg) begin
      ast_low_cnt <= 20'h00000;
    end else begin
      ast_low_cnt <= ast_low_cnt + 20'h00001;
    end
  end

  AST_AMB_TIME: assert property (
    $rose(dr_reg) && meas_select_bits == 7'h20 |-> ast_low_cnt == P_AMB_CYC)
    else $error("ambient-only duration wrong");
  AST_DCACT_TIME: assert property (
    $rose(dr_reg) && (meas_select_bits & 7'h53) == 7'h13 |-> ast_low_cnt == P_DCACT_CYC)
    else $error("dc plus active duration wrong");
  AST_ALL_TIME: assert property (
    $rose(dr_reg) && (meas_select_bits & 7'h73) == 7'h73 |-> ast_low_cnt == P_ALL_CYC)
    else $error("full measurement duration wrong");
  AST_START_DR: assert property (
    start_go |=> !dr_reg && measuring ##1 !dr_reg)
    else $error("ready did not drop after start");
  AST_PARITY: assert property (
    par_err |=> invalid_reg && st_reg == $past(st_reg))
    else $error("parity error not flagged");
  AST_BUSY: assert property (
    !dr_reg && !cr_go |=> st_reg != lsr_pkg::LSR_IDLE || dr_reg)
    else $error("command accepted while busy");
  AST_CR: assert property (
    cr_go |=> st_reg == lsr_pkg::LSR_STARTUP && !dr_reg && !valid_reg)
    else $error("chip reset not executed");
  AST_STBY: assert property (
    standby_reg && dr_reg && st_reg == lsr_pkg::LSR_IDLE && !cr_go |=> !measuring)
    else $error("start accepted in standby");
  AST_CLEAR: assert property (
    ro_end |=> !valid_reg && res_mem[0] == '0)
    else $error("data not cleared after read-out");
  AST_TEST_NO_LED: assert property (
    tp_a_reg || tp_b_reg |-> !led_a_reg && !led_b_reg)
    else $error("led fired in test mode");

  COV_START: cover property (start_go ##[1:1000] measuring);
  COV_READOUT: cover property (ro_end);
  COV_CR_BUSY: cover property (cr_go && measuring);
endmodule

// [hw/lsr_params.svh]
// Constants for the light sensor measure and read-out block
`ifndef LSR_PARAMS_SVH
`define LSR_PARAMS_SVH

`define CLK_MHZ        125

`define T_TEMP_MIN_US  269
`define T_TEMP_MAX_US  298
`define T_AMB_MIN_US   388
`define T_AMB_MAX_US   430
`define T_ACT_MIN_US   1513
`define T_ACT_MAX_US   1673
`define T_DCACT_MIN_US 1811
`define T_DCACT_MAX_US 2002
`define T_ALL_MIN_US   2079
`define T_ALL_MAX_US   2299
`define T_STARTUP_US   10

`define T_TEMP_CYC     (((`T_TEMP_MIN_US + `T_TEMP_MAX_US) / 2) * `CLK_MHZ)
`define T_AMB_CYC      (((`T_AMB_MIN_US + `T_AMB_MAX_US) / 2) * `CLK_MHZ)
`define T_ACT_CYC      (((`T_ACT_MIN_US + `T_ACT_MAX_US) / 2) * `CLK_MHZ)
`define T_DCACT_CYC    (((`T_DCACT_MIN_US + `T_DCACT_MAX_US) / 2) * `CLK_MHZ)
`define T_ALL_CYC      (((`T_ALL_MIN_US + `T_ALL_MAX_US) / 2) * `CLK_MHZ)
`define T_STARTUP_CYC  (`T_STARTUP_US * `CLK_MHZ)

`define CMD_SM_HI      4'hD
`define CMD_SD         8'hB0
`define CMD_RO         8'hC3
`define CMD_CR         8'hF0

`define SEL_TEMP       6
`define SEL_AMB        5
`define SEL_DC         4
`define SEL_LEDA       3
`define SEL_LEDB       2
`define SEL_ACTA       1
`define SEL_ACTB       0

`define REG_CTRL       12'h000
`define REG_STAT       12'h004
`define CTRL_RST       5'h03
`define STAT_INV       1

`define FIRST_IDX      5'h03
`define CRC_IDX        5'h17
`define CRC_POLY       8'h07
`define CRC_INIT       8'h00
`define AFE_SLOTS      9
`define WORD_W         16

`define PULSE_BASE_UA  5'h05

`endif

// [hw/lsr_pkg.sv]
// Types for the light sensor measure and read-out block
package lsr_pkg;
  typedef enum logic [1:0] {LSR_IDLE, LSR_MEAS, LSR_STARTUP} lsr_state_t;
endpackage
